/* File: verilog/dsd_pkg.sv */
/*
 * constants for the data space decoder: address map, window and bank
 * layouts, select codes.
 * assumes the cpu core presents 8-bit data addresses on one clock.
 */
package dsd_pkg;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam logic [7:0] BANK_LO = 8'h00;
	localparam logic [7:0] BANK_HI = 8'h3F;
	localparam logic [7:0] WIN_LO = 8'h40;
	localparam logic [7:0] WIN_HI = 8'h7F;
	localparam logic [7:0] IDX_X = 8'h80;
	localparam logic [7:0] IDX_Y = 8'h81;
	localparam logic [7:0] SHORT_V = 8'h82;
	localparam logic [7:0] SHORT_W = 8'h83;
	localparam logic [7:0] RAM_LO = 8'h84;
	localparam logic [7:0] RAM_HI = 8'hBF;
	localparam logic [7:0] PDATA_LO = 8'hC0;
	localparam logic [7:0] PDATA_HI = 8'hC2;
	localparam logic [7:0] PDIR_LO = 8'hC4;
	localparam logic [7:0] PDIR_HI = 8'hC6;
	localparam logic [7:0] IRQ_OPT = 8'hC8;
	localparam logic [7:0] WIN_PAGE = 8'hC9;
	localparam logic [7:0] POPT_LO = 8'hCC;
	localparam logic [7:0] POPT_HI = 8'hCE;
	localparam logic [7:0] CONV_LO = 8'hD0;
	localparam logic [7:0] CONV_HI = 8'hD1;
	localparam logic [7:0] TMR_LO = 8'hD2;
	localparam logic [7:0] TMR_HI = 8'hD4;
	localparam logic [7:0] ART_A_LO = 8'hD5;
	localparam logic [7:0] ART_A_HI = 8'hD7;
	localparam logic [7:0] WDOG = 8'hD8;
	localparam logic [7:0] ART_B_LO = 8'hD9;
	localparam logic [7:0] ART_B_HI = 8'hDB;
	localparam logic [7:0] BANK_SEL = 8'hE8;
	localparam logic [7:0] NV_CTL = 8'hEA;
	localparam logic [7:0] ACCUM = 8'hFF;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	localparam int WIN_BITS = 6;
	localparam int PM_BITS = 12;
	localparam int BANK_RAM2_BIT = 4;
	localparam int BANK_EE0_BIT = 0;
	localparam int STACK_DEPTH = 6;
	localparam logic [7:0] UNDEF_READ = 8'h00;

	// ----------------------------------------------------------------
	// target select codes
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		DSD_SEL_NONE = 5'h00,
		DSD_SEL_BANK_RAM2 = 5'h01,
		DSD_SEL_BANK_EE0 = 5'h02,
		DSD_SEL_WINDOW = 5'h03,
		DSD_SEL_CORE = 5'h04,
		DSD_SEL_RAM = 5'h05,
		DSD_SEL_PORT_DATA = 5'h06,
		DSD_SEL_PORT_DIR = 5'h07,
		DSD_SEL_PORT_OPT = 5'h08,
		DSD_SEL_IRQ_OPT = 5'h09,
		DSD_SEL_WIN_PAGE = 5'h0A,
		DSD_SEL_CONV = 5'h0B,
		DSD_SEL_TIMER = 5'h0C,
		DSD_SEL_ARTIMER = 5'h0D,
		DSD_SEL_WDOG = 5'h0E,
		DSD_SEL_BANK_REG = 5'h0F,
		DSD_SEL_NV_CTL = 5'h10
	} dsd_sel_t;

endpackage : dsd_pkg

/* File: verilog/dsd_decoder.sv */
/*
 * data space decoder with program memory read window, bank select and
 * return address stack.
 * assumes one cpu access per cycle, program memory and peripheral files
 * answer combinationally in the same cycle; read data is registered.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - reads at 40h-7Fh come from program memory
// - window: 64 bytes, 64-byte steps, 0-FFFh
// - address is window page then six low bits
// - window page write-only at C9h
// - window page not cleared by reset
// - 00h-3Fh goes to selected bank
// - resident 60-byte ram at 84h-BFh
// - index 80-81h, short 82-83h, accumulator FFh
// - port data, direction, option groups decoded
// - converter, timer, watchdog registers decoded
// - auto-reload timer registers decoded
// - irq option, bank select, nv control decoded
// - six-entry 12-bit return stack, off data space
// - program counter is 12 bits
// - readout protection blocks external reads only
// - window page uses bits 5-0 only
// - bank bit 4 ram page 2, bit 0 eeprom
module dsd_decoder (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// cpu data access
	input wire logic [7:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	// cpu stack and program counter
	input wire logic stk_push,
	input wire logic stk_pop,
	input wire logic [11:0] stk_push_pc,
	output logic [11:0] stk_top_pc,
	output logic stk_overflow,
	// program memory
	output logic [11:0] pm_addr,
	input wire logic [7:0] pm_rdata,
	// external readout port of program memory
	input wire logic readout_protect,
	input wire logic ext_rd,
	input wire logic [11:0] ext_addr,
	output logic [7:0] ext_rdata,
	// target selects and data toward ram, banks, core, peripherals
	output logic [4:0] tgt_sel,
	output logic [5:0] tgt_index,
	output logic tgt_rd,
	output logic tgt_wr,
	output logic [7:0] tgt_wdata,
	input wire logic [7:0] tgt_rdata
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	logic [5:0] rom_window_page_reg;
	logic [1:0] data_bank_select_reg;
	dsd_pkg::dsd_sel_t dec_sel;
	logic [5:0] dec_index;

	always_comb begin
		dec_sel = dsd_pkg::DSD_SEL_NONE;
		dec_index = cpu_addr[5:0];
		if (in_range(cpu_addr, dsd_pkg::BANK_LO, dsd_pkg::BANK_HI)) begin
			if (data_bank_select_reg[1])
				dec_sel = dsd_pkg::DSD_SEL_BANK_RAM2;
			else if (data_bank_select_reg[0])
				dec_sel = dsd_pkg::DSD_SEL_BANK_EE0;
		end
		else if (in_range(cpu_addr, dsd_pkg::WIN_LO, dsd_pkg::WIN_HI))
			dec_sel = dsd_pkg::DSD_SEL_WINDOW;
		else if (in_range(cpu_addr, dsd_pkg::IDX_X, dsd_pkg::SHORT_W)) begin
			dec_sel = dsd_pkg::DSD_SEL_CORE;
			dec_index = {4'h0, cpu_addr[1:0]};
		end
		else if (cpu_addr == dsd_pkg::ACCUM) begin
			dec_sel = dsd_pkg::DSD_SEL_CORE;
			dec_index = 6'h04;
		end
		else if (in_range(cpu_addr, dsd_pkg::RAM_LO, dsd_pkg::RAM_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_RAM;
			dec_index = 6'(cpu_addr - dsd_pkg::RAM_LO);
		end
		else if (in_range(cpu_addr, dsd_pkg::PDATA_LO, dsd_pkg::PDATA_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_PORT_DATA;
			dec_index = {4'h0, cpu_addr[1:0]};
		end
		else if (in_range(cpu_addr, dsd_pkg::PDIR_LO, dsd_pkg::PDIR_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_PORT_DIR;
			dec_index = {4'h0, cpu_addr[1:0]};
		end
		else if (in_range(cpu_addr, dsd_pkg::POPT_LO, dsd_pkg::POPT_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_PORT_OPT;
			dec_index = {4'h0, cpu_addr[1:0]};
		end
		// irq option, window page, bank and nv control
		else if (cpu_addr == dsd_pkg::IRQ_OPT) begin
			dec_sel = dsd_pkg::DSD_SEL_IRQ_OPT;
			dec_index = 6'h00;
		end
		else if (cpu_addr == dsd_pkg::WIN_PAGE) begin
			dec_sel = dsd_pkg::DSD_SEL_WIN_PAGE;
			dec_index = 6'h00;
		end
		else if (cpu_addr == dsd_pkg::BANK_SEL) begin
			dec_sel = dsd_pkg::DSD_SEL_BANK_REG;
			dec_index = 6'h00;
		end
		else if (cpu_addr == dsd_pkg::NV_CTL) begin
			dec_sel = dsd_pkg::DSD_SEL_NV_CTL;
			dec_index = 6'h00;
		end
		else if (in_range(cpu_addr, dsd_pkg::CONV_LO, dsd_pkg::CONV_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_CONV;
			dec_index = 6'(cpu_addr - dsd_pkg::CONV_LO);
		end
		else if (in_range(cpu_addr, dsd_pkg::TMR_LO, dsd_pkg::TMR_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_TIMER;
			dec_index = 6'(cpu_addr - dsd_pkg::TMR_LO);
		end
		else if (cpu_addr == dsd_pkg::WDOG) begin
			dec_sel = dsd_pkg::DSD_SEL_WDOG;
			dec_index = 6'h00;
		end
		else if (in_range(cpu_addr, dsd_pkg::ART_A_LO, dsd_pkg::ART_A_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_ARTIMER;
			dec_index = 6'(cpu_addr - dsd_pkg::ART_A_LO);
		end
		else if (in_range(cpu_addr, dsd_pkg::ART_B_LO, dsd_pkg::ART_B_HI)) begin
			dec_sel = dsd_pkg::DSD_SEL_ARTIMER;
			dec_index = 6'(6'h03 + 6'(cpu_addr - dsd_pkg::ART_B_LO));
		end
		else
			dec_sel = dsd_pkg::DSD_SEL_NONE;
	end

	// ----------------------------------------------------------------
	// write-only registers
	// ----------------------------------------------------------------
	logic is_local;
	assign is_local = (dec_sel == dsd_pkg::DSD_SEL_WIN_PAGE) ||
		(dec_sel == dsd_pkg::DSD_SEL_BANK_REG);

	// page keeps bits 5-0, left alone by reset
	always_ff @(posedge clk) begin
		if (cpu_wr && dec_sel == dsd_pkg::DSD_SEL_WIN_PAGE)
			rom_window_page_reg <= cpu_wdata[dsd_pkg::WIN_BITS-1:0];
	end

	// bank select bits, not cleared at reset
	always_ff @(posedge clk) begin
		if (cpu_wr && dec_sel == dsd_pkg::DSD_SEL_BANK_REG)
			data_bank_select_reg <= {cpu_wdata[dsd_pkg::BANK_RAM2_BIT],
				cpu_wdata[dsd_pkg::BANK_EE0_BIT]};
	end

	// ----------------------------------------------------------------
	// program memory port
	// ----------------------------------------------------------------
	logic win_rd;
	logic [11:0] win_addr;
	assign win_rd = cpu_rd && dec_sel == dsd_pkg::DSD_SEL_WINDOW;
	// a page write and window read in one cycle uses the old page
	// since the cpu cannot issue both at once
	assign win_addr = {rom_window_page_reg,
		cpu_addr[dsd_pkg::WIN_BITS-1:0]};

	// cpu window wins the port; external reads gated by protection
	logic ext_ok;
	assign ext_ok = ext_rd && !readout_protect && !win_rd;

	always_ff @(posedge clk) begin
		if (!reset_n)
			pm_addr <= 12'h000;
		else if (win_rd)
			pm_addr <= win_addr;
		else if (ext_ok)
			pm_addr <= ext_addr;
	end

	logic ext_pend_reg;
	logic win_pend_reg;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ext_pend_reg <= 1'b0;
			win_pend_reg <= 1'b0;
		end else begin
			ext_pend_reg <= ext_ok;
			win_pend_reg <= win_rd;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			ext_rdata <= 8'h00;
		else if (ext_pend_reg)
			ext_rdata <= pm_rdata;
		else if (ext_rd && readout_protect)
			ext_rdata <= 8'h00;
	end

	// ----------------------------------------------------------------
	// target strobes and read data
	// ----------------------------------------------------------------
	// local, window and unmapped accesses never strobe out
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tgt_sel <= 5'h00;
			tgt_index <= 6'h00;
			tgt_rd <= 1'b0;
			tgt_wr <= 1'b0;
			tgt_wdata <= 8'h00;
		end else begin
			tgt_sel <= dec_sel;
			tgt_index <= dec_index;
			tgt_rd <= cpu_rd && !is_local &&
				dec_sel != dsd_pkg::DSD_SEL_NONE &&
				dec_sel != dsd_pkg::DSD_SEL_WINDOW &&
				dec_sel != dsd_pkg::DSD_SEL_IRQ_OPT;
			tgt_wr <= cpu_wr && !is_local &&
				dec_sel != dsd_pkg::DSD_SEL_NONE &&
				dec_sel != dsd_pkg::DSD_SEL_WINDOW;
			tgt_wdata <= cpu_wdata;
		end
	end

	// window data from program memory, targets otherwise
	always_ff @(posedge clk) begin
		if (!reset_n)
			cpu_rdata <= dsd_pkg::UNDEF_READ;
		else if (win_pend_reg)
			cpu_rdata <= pm_rdata;
		else if (tgt_rd)
			cpu_rdata <= tgt_rdata;
		else
			cpu_rdata <= dsd_pkg::UNDEF_READ;
	end

	// ----------------------------------------------------------------
	// return address stack
	// ----------------------------------------------------------------
	// six 12-bit entries; overflow drops the oldest
	logic [11:0] stack_mem [dsd_pkg::STACK_DEPTH];
	logic [2:0] stk_cnt_reg;

	always_ff @(posedge clk) begin
		if (stk_push) begin
			stack_mem[0] <= stk_push_pc;
			for (int i = 1; i < dsd_pkg::STACK_DEPTH; i++)
				stack_mem[i] <= stack_mem[i-1];
		end else if (stk_pop) begin
			for (int i = 0; i < dsd_pkg::STACK_DEPTH - 1; i++)
				stack_mem[i] <= stack_mem[i+1];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stk_cnt_reg <= 3'h0;
			stk_overflow <= 1'b0;
		end else if (stk_push) begin
			if (stk_cnt_reg == 3'(dsd_pkg::STACK_DEPTH))
				stk_overflow <= 1'b1;
			else
				stk_cnt_reg <= stk_cnt_reg + 3'h1;
		end else if (stk_pop && stk_cnt_reg != 3'h0)
			stk_cnt_reg <= stk_cnt_reg - 3'h1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			stk_top_pc <= 12'h000;
		else if (stk_push)
			stk_top_pc <= stk_push_pc;
		else if (stk_pop)
			stk_top_pc <= stack_mem[1];
	end

endmodule : dsd_decoder

/* File: bench/dsd_decoder_monitor.sv */
/*
 * checker on the data space decoder ports.
 * assumes one clock, sync active-low reset, bound in from the bench.
 */
`timescale 1ns/1ps
module dsd_decoder_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// cpu access
	input wire logic [7:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata,
	// stack
	input wire logic stk_push,
	input wire logic stk_pop,
	input wire logic [11:0] stk_push_pc,
	input wire logic [11:0] stk_top_pc,
	input wire logic stk_overflow,
	// program memory and readout
	input wire logic [11:0] pm_addr,
	input wire logic [7:0] pm_rdata,
	input wire logic readout_protect,
	input wire logic ext_rd,
	input wire logic [11:0] ext_addr,
	input wire logic [7:0] ext_rdata,
	// targets
	input wire logic [4:0] tgt_sel,
	input wire logic [5:0] tgt_index,
	input wire logic tgt_rd,
	input wire logic tgt_wr,
	input wire logic [7:0] tgt_wdata,
	input wire logic [7:0] tgt_rdata
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire win_rd = cpu_rd && cpu_addr >= 8'h40 && cpu_addr <= 8'h7F;
	wire ram_rd = cpu_rd && cpu_addr >= 8'h84 && cpu_addr <= 8'hBF;
	sequence page_set;
		cpu_wr && cpu_addr == 8'hC9;
	endsequence
	sequence win_fetch;
		win_rd && !cpu_wr;
	endsequence
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// low bits
	win_low_a: assert property (
		win_rd |=> pm_addr[5:0] == $past(cpu_addr[5:0]))
		else $error("window low address bits wrong");
	win_page_a: assert property (
		page_set ##1 win_fetch |=> pm_addr[11:6] == $past(cpu_wdata[5:0], 2))
		else $error("window page bits wrong");
	win_data_a: assert property (
		win_rd |-> ##2 cpu_rdata == $past(pm_rdata))
		else $error("window read data wrong");
	ram_sel_a: assert property (
		ram_rd |=> tgt_rd && tgt_sel == dsd_pkg::DSD_SEL_RAM
		&& tgt_index == 6'($past(cpu_addr) - 8'h84))
		else $error("resident ram select wrong");
	wo_quiet_a: assert property (
		(cpu_rd || cpu_wr) && cpu_addr == 8'hC9 |=> !tgt_rd && !tgt_wr)
		else $error("window page access strobed out");
	core_acc_a: assert property (
		cpu_rd && cpu_addr == 8'hFF |=> tgt_rd && tgt_index == 6'h04)
		else $error("accumulator select wrong");
	tgt_data_a: assert property (
		tgt_rd |=> cpu_rdata == $past(tgt_rdata))
		else $error("target read data wrong");
	stk_top_a: assert property (
		stk_push |=> stk_top_pc == $past(stk_push_pc))
		else $error("stack top wrong after push");
	protect_a: assert property (
		ext_rd && readout_protect |-> ##2 ext_rdata == 8'h00)
		else $error("protected readout leaked data");
endmodule : dsd_decoder_monitor

/* File: bench/dsd_far_model.sv */
/*
 * far side model: program memory and target register files.
 * assumes both answer combinationally, as the decoder expects.
 */
`timescale 1ns/1ps
module dsd_far_model (
	// program memory
	input wire logic [11:0] pm_addr,
	output logic [7:0] pm_rdata,
	// targets
	input wire logic [4:0] tgt_sel,
	input wire logic [5:0] tgt_index,
	input wire logic tgt_rd,
	output logic [7:0] tgt_rdata
);
	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	// byte per address
	assign pm_rdata = pm_addr[7:0] ^ {pm_addr[11:8], 4'h9};
	// unstrobed: inverse, so stale data never matches
	assign tgt_rdata = tgt_rd ? {tgt_sel[1:0], tgt_index}
		: ~{tgt_sel[1:0], tgt_index};
endmodule : dsd_far_model

/* File: bench/dsd_decoder_bench.sv */
/*
 * self-checking bench for the data space decoder.
 * assumes the far side model and the port checker beside it.
 */
`timescale 1ns/1ps
module dsd_decoder_bench;
	logic clk = 0, reset_n = 0, cpu_rd = 0, cpu_wr = 0;
	logic stk_push = 0, stk_pop = 0, readout_protect = 0, ext_rd = 0;
	logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00;
	logic [11:0] stk_push_pc = 12'h000, ext_addr = 12'h000;
	logic [7:0] cpu_rdata, pm_rdata, ext_rdata, tgt_wdata, tgt_rdata;
	logic [11:0] stk_top_pc, pm_addr;
	logic stk_overflow, tgt_rd, tgt_wr;
	logic [4:0] tgt_sel;
	logic [5:0] tgt_index;
	int err_total = 0, check_count = 0;
	logic [23:0] tbl [16] = '{24'h80_0400, 24'h83_0403, 24'hFF_0404,
		24'h84_0500, 24'hBF_053B, 24'hC0_0600, 24'hC2_0602, 24'hC4_0700,
		24'hCE_0802, 24'hD1_0B01, 24'hD2_0C00, 24'hD4_0C02, 24'hD5_0D00,
		24'hDB_0D05, 24'hD8_0E00, 24'hEA_1000};
	always #50 clk = ~clk;
	dsd_decoder i_dut (.*);
	dsd_far_model i_far (.*);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] pmv(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], 4'h9};
	endfunction : pmv
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu_wr = 1;
		cpu_addr = a;
		cpu_wdata = d;
		@(posedge clk);
		#1 cpu_wr = 0;
	endtask : wr
	// mode 0 blank read, 1 target read, 2 window read
	task automatic rd(input logic [7:0] a, input int m,
		input logic [4:0] s, input logic [11:0] x);
		cpu_rd = 1;
		cpu_addr = a;
		@(posedge clk);
		#1 cpu_rd = 0;
		// strobe, select and address stand in the cycle after the take
		chk(tgt_rd, m == 1);
		if (m == 1) chk(tgt_sel, s);
		if (m == 1) chk(tgt_index, x);
		if (m == 2) chk(pm_addr, x);
		// read data stands for one cycle only, one edge later
		@(posedge clk);
		#1;
		chk(cpu_rdata, m == 2 ? pmv(x) : m == 1 ? {s[1:0], x[5:0]} : 8'h00);
	endtask : rd
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#100_000;
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1;
		wr(8'hC9, 8'hC5);
		rd(8'h43, 2, 5'h00, 12'h143);
		wr(8'hC9, 8'h3F);
		rd(8'h7F, 2, 5'h00, 12'hFFF);
		wr(8'hC9, 8'h00);
		rd(8'h40, 2, 5'h00, 12'h000);
		$display("test window done");
		for (int k = 0; k < 16; k++) begin
			rd(tbl[k][23:16], 1, tbl[k][12:8], {6'h00, tbl[k][5:0]});
		end
		wr(8'hC8, 8'h12);
		chk(tgt_wr, 1);
		chk(tgt_sel, 5'h09);
		chk(tgt_wdata, 8'h12);
		// let an edge pass so the write strobe is not lowered and raised
		@(posedge clk);
		#1;
		wr(8'hC9, 8'h01);
		chk(tgt_wr, 0);
		$display("test decode done");
		rd(8'hCA, 0, 5'h00, 12'h000);
		rd(8'hC8, 0, 5'h00, 12'h000);
		rd(8'hC3, 0, 5'h00, 12'h000);
		rd(8'hE9, 0, 5'h00, 12'h000);
		$display("test reserved done");
		wr(8'hE8, 8'h10);
		rd(8'h05, 1, 5'h01, 12'h005);
		wr(8'hE8, 8'h01);
		rd(8'h3F, 1, 5'h02, 12'h03F);
		wr(8'hE8, 8'h00);
		rd(8'h00, 0, 5'h00, 12'h000);
		$display("test bank done");
		stk_push = 1;
		for (int i = 1; i <= 7; i++) begin
			stk_push_pc = 12'(i);
			@(posedge clk);
			#1;
		end
		stk_push = 0;
		chk(stk_overflow, 1);
		chk(stk_top_pc, 12'h007);
		stk_pop = 1;
		repeat (5) @(posedge clk);
		#1 stk_pop = 0;
		chk(stk_top_pc, 12'h002);
		$display("test stack done");
		// unprotected readout first, so the blank answer below can fail
		ext_addr = 12'h143;
		ext_rd = 1;
		@(posedge clk);
		#1 ext_rd = 0;
		@(posedge clk);
		#1;
		chk(ext_rdata, pmv(12'h143));
		readout_protect = 1;
		ext_rd = 1;
		@(posedge clk);
		#1 ext_rd = 0;
		repeat (2) @(posedge clk);
		#1;
		chk(ext_rdata, 12'h000);
		wr(8'hC9, 8'h05);
		rd(8'h43, 2, 5'h00, 12'h143);
		$display("test protect done");
		end_of_test();
	end
endmodule : dsd_decoder_bench
bind dsd_decoder dsd_decoder_monitor i_mon (.*);
